// ### rtl/usart_pkg.sv
// constants, register layouts and state encodings of the serial transceiver
// assumes a 32-bit apb master and a single peripheral clock
package usart_pkg;

	// register byte offsets
	localparam logic [11:0] ADDR_DATA = 12'h000;
	localparam logic [11:0] ADDR_CTRL = 12'h004;
	localparam logic [11:0] ADDR_BAUD = 12'h008;
	localparam logic [11:0] ADDR_STAT = 12'h00C;
	localparam logic [11:0] ADDR_MASK = 12'h010;
	localparam logic [11:0] ADDR_TOUT = 12'h014;

	// control register layout
	typedef struct packed {
		logic [12:0] zero_hi;
		logic [2:0]  rx_thr;
		logic        zero_15;
		logic        brk_send;
		logic        rx_en;
		logic        tx_en;
		logic        flow;
		logic        rs485;
		logic        irda;
		logic        single;
		logic        lin;
		logic        sync;
		logic        msb_first;
		logic        stop2;
		logic        odd;
		logic        par_en;
		logic [1:0]  wlen;
	} ctrl_s;

	// sticky event flags, also the mask layout
	typedef struct packed {
		logic timeout;
		logic rx_thr;
		logic tx_empty;
		logic brk;
		logic overrun;
		logic framing;
		logic parity;
	} flags_s;

	// status word seen by software
	typedef struct packed {
		logic [15:0] zero_hi;
		logic [3:0]  rx_level;
		logic [3:0]  tx_level;
		logic        tx_busy;
		flags_s      flags;
	} stat_s;

	localparam logic [31:0] CTRL_RESET = 32'h0000_3001;
	// bits 18:16 and 14:0 of the control word are writable, the rest read as zero
	localparam logic [31:0] CTRL_WRITABLE = 32'h0007_7FFF;
	localparam logic [15:0] BAUD_RESET = 16'h0001;
	localparam logic [7:0]  TOUT_RESET = 8'h00;

	// word length codes
	localparam logic [1:0] WLEN_7 = 2'h0;
	localparam logic [1:0] WLEN_9 = 2'h2;

	// sample ticks per bit, as last index of a down counter
	localparam logic [3:0] ASYNC_LAST = 4'h F;
	localparam logic [3:0] SYNC_LAST  = 4'h7;
	localparam logic [3:0] ASYNC_HALF = 4'h7;
	localparam logic [3:0] SYNC_HALF  = 4'h3;
	// ir pulse lasts 3 of 16 ticks
	localparam logic [3:0] IRDA_FROM  = 4'hD;
	// lin break length in bit periods, as last index
	localparam logic [3:0] LIN_BREAK_LAST = 4'hC;

	typedef enum logic [5:0] {
		TX_IDLE   = 6'h01,
		TX_START  = 6'h02,
		TX_DATA   = 6'h04,
		TX_PARITY = 6'h08,
		TX_STOP   = 6'h10,
		TX_BREAK  = 6'h20
	} tx_state_e;

	typedef enum logic [4:0] {
		RX_IDLE   = 5'h01,
		RX_START  = 5'h02,
		RX_DATA   = 5'h04,
		RX_PARITY = 5'h08,
		RX_STOP   = 5'h10
	} rx_state_e;

endpackage

// ### rtl/usart_core.sv
// serial transceiver with apb registers, 8-deep queues and one interrupt line
// assumes an apb master on I_MCLK; line pins are asynchronous and are synchronised here
//
// Overview of operation
// - asynchronous framing or synchronous mode with a bit clock on O_SCK
// - fastest bit rate is clock/16 asynchronous, clock/8 synchronous
// - transmitter and receiver run independently at the same time
// - lin mode with break, and single-wire mode sharing the transmit pin
// - character length of seven, eight or nine bits both ways
// - even, odd or no parity; generated on send, checked on receive
// - one or two stop bits after each transmitted character
// - bits sent and assembled lsb first or msb first
// - receiver flags parity error, overrun and missing stop bit
// - with flow control, drive rts and wait for cts before sending
// - infrared pulse encoder on transmit and decoder on receive
// - rs485 driver enable high only while transmitting
// - transmit and receive each have an eight entry queue
// - four interrupt sources: line status, tx empty, rx threshold, timeout
// - readable status register with error and break indications
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

module usart_core
	import usart_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
)(
	// clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RESET,
	// apb slave
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	// serial line
	input  wire logic        I_RXD,
	input  wire logic        I_TXD,
	output logic             O_TXD,
	output logic             O_TXD_OE,
	output logic             O_SCK,
	// flow control and line driver
	input  wire logic        I_CTS_N,
	output logic             O_RTS_N,
	output logic             O_DE,
	// interrupt
	output logic             O_IRQ
);

	localparam int PW = $clog2(FIFO_DEPTH);

	generate
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > 8 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
			$error("FIFO_DEPTH must be 2, 4 or 8");
		end
	endgenerate

	typedef struct packed {
		logic [2:0]                  rxd_s;
		logic [2:0]                  pin_s;
		logic [2:0]                  cts_s;
		logic                        rx_line;
		logic                        pin_line;
		logic                        cts_n;
		logic [15:0]                 div_cnt;
		ctrl_s                       ctrl;
		logic [15:0]                 baud;
		logic [7:0]                  tout;
		flags_s                      flags;
		flags_s                      mask;
		logic [FIFO_DEPTH-1:0][8:0]  txq;
		logic [PW-1:0]               txq_rd;
		logic [PW-1:0]               txq_wr;
		logic [PW:0]                 txq_n;
		logic [FIFO_DEPTH-1:0][8:0]  rxq;
		logic [PW-1:0]               rxq_rd;
		logic [PW-1:0]               rxq_wr;
		logic [PW:0]                 rxq_n;
		tx_state_e                   tx_st;
		logic [3:0]                  tx_cnt;
		logic [3:0]                  tx_idx;
		logic [8:0]                  tx_data;
		rx_state_e                   rx_st;
		logic [3:0]                  rx_cnt;
		logic [3:0]                  rx_idx;
		logic [8:0]                  rx_data;
		logic [3:0]                  ir_cnt;
		logic [7:0]                  tout_cnt;
		logic                        tout_armed;
		logic [31:0]                 prdata;
		logic                        pready;
		logic                        pslverr;
		logic                        txd;
		logic                        txd_oe;
		logic                        sck;
		logic                        rts_n;
		logic                        de;
		logic                        irq;
	} state_s;

	state_s s;
	state_s next_s;

	function automatic logic [3:0] char_bits(input logic [1:0] wlen);
		if (wlen == WLEN_7) begin
			return 4'h7;
		end else if (wlen == WLEN_9) begin
			return 4'h9;
		end
		return 4'h8;
	endfunction

	function automatic logic [8:0] char_mask(input logic [1:0] wlen);
		if (wlen == WLEN_7) begin
			return 9'h07F;
		end else if (wlen == WLEN_9) begin
			return 9'h1FF;
		end
		return 9'h0FF;
	endfunction

	always_comb begin
		logic        tick;
		logic        access;
		logic        done;
		logic        wr;
		logic        rd;
		logic        hit;
		logic [31:0] rdata;
		logic [3:0]  last;
		logic [3:0]  half;
		logic [3:0]  nbits;
		logic [3:0]  pos;
		logic        rx_raw;
		logic        rx_bit;
		logic        tx_push;
		logic        tx_pop;
		logic        rx_push;
		logic        rx_pop;
		logic        tx_bit;
		logic        busy;
		logic [3:0]  thr;
		flags_s      set;
		flags_s      clr;
		stat_s       stat;

		next_s = s;
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		set = '0;
		clr = '0;
		rdata = '0;
		hit = 1'b1;
		tx_bit = 1'b1;

		// three-stage synchronisers, a change counts once stages two and three agree
		next_s.rxd_s = {s.rxd_s[1:0], I_RXD};
		next_s.pin_s = {s.pin_s[1:0], I_TXD};
		next_s.cts_s = {s.cts_s[1:0], I_CTS_N};
		if (s.rxd_s[1] == s.rxd_s[2]) begin
			next_s.rx_line = s.rxd_s[2];
		end
		if (s.pin_s[1] == s.pin_s[2]) begin
			next_s.pin_line = s.pin_s[2];
		end
		if (s.cts_s[1] == s.cts_s[2]) begin
			next_s.cts_n = s.cts_s[2];
		end

		// sample-tick divider; divisor 1 gives one tick per clock
		tick = (s.div_cnt == 16'h0000);
		if (tick) begin
			next_s.div_cnt = (s.baud == 16'h0000) ? 16'h0000 : s.baud - 16'h0001;
		end else begin
			next_s.div_cnt = s.div_cnt - 16'h0001;
		end
		last = s.ctrl.sync ? SYNC_LAST : ASYNC_LAST;
		half = s.ctrl.sync ? SYNC_HALF : ASYNC_HALF;
		nbits = char_bits(s.ctrl.wlen);

		// receive line select and infrared pulse stretcher
		rx_raw = s.ctrl.single ? s.pin_line : s.rx_line;
		if (s.ctrl.irda && rx_raw) begin
			next_s.ir_cnt = ASYNC_LAST;
		end else if (tick && s.ir_cnt != 4'h0) begin
			next_s.ir_cnt = s.ir_cnt - 4'h1;
		end
		rx_bit = s.ctrl.irda ? (!rx_raw && s.ir_cnt == 4'h0) : rx_raw;

		// apb: access phase answered one cycle after it starts
		access = I_PSEL && I_PENABLE;
		done = access && s.pready;
		wr = done && I_PWRITE;
		rd = done && !I_PWRITE;
		stat.zero_hi = '0;
		stat.rx_level = 4'(s.rxq_n);
		stat.tx_level = 4'(s.txq_n);
		stat.tx_busy = (s.tx_st != TX_IDLE);
		stat.flags = s.flags;
		case (I_PADDR)
			ADDR_DATA: rdata = {23'h00_0000, s.rxq[s.rxq_rd]};
			ADDR_CTRL: rdata = s.ctrl;
			ADDR_BAUD: rdata = {16'h0000, s.baud};
			ADDR_STAT: rdata = stat;
			ADDR_MASK: rdata = {25'h000_0000, s.mask};
			ADDR_TOUT: rdata = {24'h00_0000, s.tout};
			default:   hit = 1'b0;
		endcase
		next_s.pready = access && !s.pready;
		next_s.pslverr = access && !s.pready && !hit;
		if (access && !s.pready) begin
			next_s.prdata = (I_PWRITE || !hit) ? 32'h0000_0000 : rdata;
		end
		if (wr && hit) begin
			case (I_PADDR)
				ADDR_DATA: tx_push = (s.txq_n != (PW+1)'(FIFO_DEPTH));
				ADDR_CTRL: next_s.ctrl = ctrl_s'(I_PWDATA & CTRL_WRITABLE);
				ADDR_BAUD: next_s.baud = I_PWDATA[15:0];
				ADDR_STAT: clr = flags_s'(I_PWDATA[6:0]);
				ADDR_MASK: next_s.mask = flags_s'(I_PWDATA[6:0]);
				ADDR_TOUT: next_s.tout = I_PWDATA[7:0];
				default:   next_s.ctrl = s.ctrl;
			endcase
		end
		if (rd && hit && I_PADDR == ADDR_DATA && s.rxq_n != '0) begin
			rx_pop = 1'b1;
			next_s.tout_cnt = 8'h00;
		end

		// transmitter
		if (tick) begin
			if (s.tx_st != TX_IDLE && s.tx_cnt != 4'h0) begin
				next_s.tx_cnt = s.tx_cnt - 4'h1;
			end else begin
				next_s.tx_cnt = last;
				case (s.tx_st)
					TX_IDLE: begin
						if (s.ctrl.lin && s.ctrl.brk_send) begin
							next_s.ctrl.brk_send = 1'b0;
							next_s.tx_st = TX_BREAK;
							next_s.tx_idx = 4'h0;
						end else if (s.ctrl.tx_en && s.txq_n != '0
							&& (!s.ctrl.flow || !s.cts_n)) begin
							tx_pop = 1'b1;
							next_s.tx_data = s.txq[s.txq_rd] & char_mask(s.ctrl.wlen);
							next_s.tx_st = TX_START;
						end
					end
					TX_START: begin
						next_s.tx_st = TX_DATA;
						next_s.tx_idx = 4'h0;
					end
					TX_DATA: begin
						next_s.tx_idx = s.tx_idx + 4'h1;
						if (s.tx_idx == nbits - 4'h1) begin
							next_s.tx_idx = 4'h0;
							next_s.tx_st = s.ctrl.par_en ? TX_PARITY : TX_STOP;
						end
					end
					TX_PARITY: begin
						next_s.tx_st = TX_STOP;
						next_s.tx_idx = 4'h0;
					end
					TX_STOP: begin
						next_s.tx_idx = s.tx_idx + 4'h1;
						if (s.tx_idx == {3'h0, s.ctrl.stop2}) begin
							next_s.tx_st = TX_IDLE;
						end
					end
					TX_BREAK: begin
						next_s.tx_idx = s.tx_idx + 4'h1;
						if (s.tx_idx == LIN_BREAK_LAST) begin
							next_s.tx_st = TX_STOP;
							next_s.tx_idx = 4'h0;
						end
					end
					default: next_s.tx_st = TX_IDLE;
				endcase
			end
		end
		pos = s.ctrl.msb_first ? nbits - 4'h1 - next_s.tx_idx : next_s.tx_idx;
		case (next_s.tx_st)
			TX_START:  tx_bit = 1'b0;
			TX_BREAK:  tx_bit = 1'b0;
			TX_DATA:   tx_bit = next_s.tx_data[pos];
			TX_PARITY: tx_bit = (^next_s.tx_data) ^ s.ctrl.odd;
			default:   tx_bit = 1'b1;
		endcase
		busy = (next_s.tx_st != TX_IDLE);
		if (s.ctrl.irda) begin
			next_s.txd = busy && !tx_bit && next_s.tx_cnt >= IRDA_FROM;
		end else begin
			next_s.txd = tx_bit;
		end
		next_s.txd_oe = !s.ctrl.single || busy;
		next_s.de = s.ctrl.rs485 && busy;
		next_s.sck = s.ctrl.sync && (next_s.tx_st == TX_DATA || next_s.tx_st == TX_PARITY)
			&& next_s.tx_cnt <= half;

		// receiver, independent of the transmitter
		if (s.rx_st == RX_IDLE) begin
			if (tick) begin
				next_s.rx_cnt = (s.rx_cnt == 4'h0) ? last : s.rx_cnt - 4'h1;
				if (s.rx_cnt == 4'h0 && s.rxq_n != '0 && s.tout != 8'h00 && s.tout_armed) begin
					next_s.tout_cnt = s.tout_cnt + 8'h01;
					if (s.tout_cnt + 8'h01 >= s.tout) begin
						set.timeout = 1'b1;
						next_s.tout_armed = 1'b0;
					end
				end
			end
			if (s.ctrl.rx_en && !rx_bit) begin
				next_s.rx_st = RX_START;
				next_s.rx_cnt = half;
				next_s.rx_data = '0;
				next_s.rx_idx = 4'h0;
			end
		end else if (tick) begin
			if (s.rx_cnt != 4'h0) begin
				next_s.rx_cnt = s.rx_cnt - 4'h1;
			end else begin
				next_s.rx_cnt = last;
				pos = s.ctrl.msb_first ? nbits - 4'h1 - s.rx_idx : s.rx_idx;
				case (s.rx_st)
					RX_START: next_s.rx_st = rx_bit ? RX_IDLE : RX_DATA;
					RX_DATA: begin
						next_s.rx_data[pos] = rx_bit;
						next_s.rx_idx = s.rx_idx + 4'h1;
						if (s.rx_idx == nbits - 4'h1) begin
							next_s.rx_st = s.ctrl.par_en ? RX_PARITY : RX_STOP;
						end
					end
					RX_PARITY: begin
						set.parity = ((^s.rx_data) ^ s.ctrl.odd) != rx_bit;
						next_s.rx_st = RX_STOP;
					end
					RX_STOP: begin
						set.framing = !rx_bit;
						set.brk = !rx_bit && s.rx_data == '0;
						if (s.rxq_n == (PW+1)'(FIFO_DEPTH)) begin
							set.overrun = 1'b1;
						end else begin
							rx_push = 1'b1;
						end
						next_s.tout_cnt = 8'h00;
						next_s.tout_armed = 1'b1;
						next_s.rx_st = RX_IDLE;
					end
					default: next_s.rx_st = RX_IDLE;
				endcase
			end
		end

		// queues
		if (tx_push) begin
			next_s.txq[s.txq_wr] = I_PWDATA[8:0];
			next_s.txq_wr = s.txq_wr + PW'(1);
		end
		if (tx_pop) begin
			next_s.txq_rd = s.txq_rd + PW'(1);
		end
		next_s.txq_n = s.txq_n + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
		if (rx_push) begin
			next_s.rxq[s.rxq_wr] = next_s.rx_data;
			next_s.rxq_wr = s.rxq_wr + PW'(1);
		end
		if (rx_pop) begin
			next_s.rxq_rd = s.rxq_rd + PW'(1);
		end
		next_s.rxq_n = s.rxq_n + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
		next_s.rts_n = s.ctrl.flow && next_s.rxq_n == (PW+1)'(FIFO_DEPTH);

		// events; a set in the same cycle as a clear wins
		set.tx_empty = (s.txq_n != '0) && (next_s.txq_n == '0);
		thr = {1'b0, s.ctrl.rx_thr} + 4'h1;
		set.rx_thr = (4'(s.rxq_n) < thr) && (4'(next_s.rxq_n) >= thr);
		next_s.flags = (s.flags & ~clr) | set;
		next_s.irq = |(next_s.flags & next_s.mask);
	end

	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			s <= '0;
			s.rxd_s <= 3'h7;
			s.pin_s <= 3'h7;
			s.cts_s <= 3'h7;
			s.rx_line <= 1'b1;
			s.pin_line <= 1'b1;
			s.cts_n <= 1'b1;
			s.ctrl <= ctrl_s'(CTRL_RESET);
			s.baud <= BAUD_RESET;
			s.tout <= TOUT_RESET;
			s.tx_st <= TX_IDLE;
			s.rx_st <= RX_IDLE;
			s.txd <= 1'b1;
			s.txd_oe <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign O_PRDATA  = s.prdata;
	assign O_PREADY  = s.pready;
	assign O_PSLVERR = s.pslverr;
	assign O_TXD     = s.txd;
	assign O_TXD_OE  = s.txd_oe;
	assign O_SCK     = s.sck;
	assign O_RTS_N   = s.rts_n;
	assign O_DE      = s.de;
	assign O_IRQ     = s.irq;

endmodule

// ### test/usart_monitor.sv
// port assertions of the serial transceiver
// bound into usart_core; assumes one clock and a synchronous reset
`timescale 1ns/1ps
module usart_monitor
	import usart_pkg::*;
#(
	parameter int FIFO_DEPTH = 8
)(
	// clock and reset
	input wire logic        I_MCLK,
	input wire logic        I_RESET,
	// apb
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	// line and interrupt
	input wire logic        O_TXD,
	input wire logic        O_TXD_OE,
	input wire logic        O_RTS_N,
	input wire logic        O_DE,
	input wire logic        O_IRQ
);
	logic mapped;
	logic ctrl_wr;
	logic mask_wr;
	assign mapped = I_PADDR inside {ADDR_DATA, ADDR_CTRL, ADDR_BAUD, ADDR_STAT, ADDR_MASK, ADDR_TOUT};
	assign ctrl_wr = O_PREADY && I_PWRITE && I_PADDR == ADDR_CTRL;
	assign mask_wr = O_PREADY && I_PWRITE && I_PADDR == ADDR_MASK;
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_RESET);
	property p_ready_in_access;
		O_PREADY |-> I_PSEL && I_PENABLE && $past(I_PENABLE);
	endproperty
	a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
	property p_ready_pulse;
		O_PREADY |=> !O_PREADY;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
	property p_ready_wait;
		I_PSEL && I_PENABLE && !$past(I_PENABLE) |=> O_PREADY;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
	property p_slverr;
		O_PREADY |-> O_PSLVERR == !mapped;
	endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr does not match address");
	property p_write_zero;
		O_PREADY && I_PWRITE |-> O_PRDATA == 32'h0000_0000;
	endproperty
	a_write_zero: assert property (p_write_zero) else $error("prdata not zero on write");
	property p_txd_low;
		$fell(O_TXD) |=> !O_TXD [*7];
	endproperty
	a_txd_low: assert property (p_txd_low) else $error("transmit low shorter than a bit");
	property p_irq_mask;
		mask_wr && I_PWDATA[6:0] == 7'h00 |-> ##2 !O_IRQ;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("interrupt stays with mask clear");
	property p_rts_flow;
		ctrl_wr && !I_PWDATA[11] |-> ##2 !O_RTS_N;
	endproperty
	a_rts_flow: assert property (p_rts_flow) else $error("rts raised without flow control");
	property p_de_off;
		ctrl_wr && !I_PWDATA[10] |-> ##2 !O_DE;
	endproperty
	a_de_off: assert property (p_de_off) else $error("driver enable outside rs485 mode");
	property p_oe_on;
		ctrl_wr && !I_PWDATA[8] |-> ##2 O_TXD_OE;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("transmit pin released outside single-wire");
	c_slverr: cover property (O_PREADY && O_PSLVERR);
	c_irq: cover property ($rose(O_IRQ));
	c_rts: cover property ($rose(O_RTS_N));
	c_de: cover property ($rose(O_DE));
endmodule

bind usart_core usart_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_usart_monitor (.*);

// ### test/usart_partner.sv
// remote serial device: sends frames on the receive line, decodes the transmit pin
// assumes the bench sets cfg to the transceiver's control word before traffic
`timescale 1ns/1ps
module usart_partner
	import usart_pkg::*;
(
	// clock
	input  wire logic clk,
	// line to and from the transceiver
	input  wire logic txd,
	input  wire logic rts_n,
	output logic      rxd,
	output logic      cts_n
);
	ctrl_s      cfg = ctrl_s'(CTRL_RESET);
	logic [8:0] got_q[$];
	int         bad = 0;
	bit         stall = 1'b0;
	assign cts_n = stall;
	initial rxd = 1'b1;
	function automatic int nb();
		return cfg.wlen == WLEN_7 ? 7 : (cfg.wlen == WLEN_9 ? 9 : 8);
	endfunction
	function automatic int bl();
		return cfg.sync ? 8 : 16;
	endfunction
	task automatic send(input logic [8:0] d, input bit bad_par, input bit bad_stop);
		logic p;
		p = cfg.odd ^ bad_par;
		for (int k = 0; k < 4000 && cfg.flow && rts_n; k++) @(posedge clk);
		@(posedge clk) rxd <= 1'b0;
		repeat (bl()) @(posedge clk);
		for (int i = 0; i < nb(); i++) begin
			rxd <= cfg.msb_first ? d[nb() - 1 - i] : d[i];
			p ^= cfg.msb_first ? d[nb() - 1 - i] : d[i];
			repeat (bl()) @(posedge clk);
		end
		if (cfg.par_en) begin
			rxd <= p;
			repeat (bl()) @(posedge clk);
		end
		rxd <= !bad_stop;
		repeat (bl() * (cfg.stop2 ? 2 : 1)) @(posedge clk);
		rxd <= 1'b1;
	endtask
	// decodes each frame mid-bit and counts bad parity or stop bits
	always begin
		logic [8:0] w;
		logic       p;
		@(negedge txd);
		repeat (bl() / 2) @(posedge clk);
		w = '0;
		p = cfg.odd;
		for (int i = 0; i < nb(); i++) begin
			repeat (bl()) @(posedge clk);
			w[cfg.msb_first ? nb() - 1 - i : i] = txd;
			p ^= txd;
		end
		if (cfg.par_en) begin
			repeat (bl()) @(posedge clk);
			if (txd !== p) bad++;
		end
		for (int j = 0; j < (cfg.stop2 ? 2 : 1); j++) begin
			repeat (bl()) @(posedge clk);
			if (txd !== 1'b1) bad++;
		end
		got_q.push_back(w);
	end
endmodule

// ### test/tb_sync_async_serial_transceiver.sv
// self-checking bench: apb master, reference queues and a line partner
// assumes usart_pkg, usart_core, usart_monitor and usart_partner compiled first
`timescale 1ns/1ps
module tb_sync_async_serial_transceiver
	import usart_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, er, txd, txd_oe, rxd, cts_n, rts_n, de, irq;
	wire         txd_pin = txd_oe ? txd : 1'b1;
	logic [8:0]  m, v, u;
	logic [8:0]  exp_tx[$], exp_rx[$];
	logic [31:0] cfgs[5] = '{32'h0000_3001, 32'h0000_3424, 32'h0000_301E, 32'h0000_3041,
		32'h0000_3105};
	int          miscompares = 0;
	int          total_checks = 0;
	always #12.5 clk = ~clk;
	usart_core #(.FIFO_DEPTH(8)) i_usart_core (.I_MCLK(clk), .I_RESET(rst), .I_PSEL(psel),
		.I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RXD(rxd),
		.I_TXD(txd_pin), .O_TXD(txd), .O_TXD_OE(txd_oe), .O_SCK(), .I_CTS_N(cts_n),
		.O_RTS_N(rts_n), .O_DE(de), .O_IRQ(irq));
	usart_partner i_usart_partner (.clk(clk), .txd(txd_pin), .rts_n(rts_n), .rxd(rxd),
		.cts_n(cts_n));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			miscompares++;
			$display("unexpected pready: expected 1 seen %b", pready);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, '0);
		chk(nm, e, rd);
	endtask
	task automatic rdd(input logic [8:0] e);
		apb(1'b0, ADDR_DATA, '0);
		chk("rx data", {23'h0, e}, rd & {23'h0, m});
	endtask
	task automatic wait_got(input int n);
		for (int i = 0; i < 8000 && i_usart_partner.got_q.size() < n; i++) @(posedge clk);
		repeat (40) @(posedge clk);
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		stop_test();
	end
	initial begin
		void'($urandom(88029));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(ADDR_CTRL, CTRL_RESET, "ctrl");
		rdc(ADDR_BAUD, 32'h0000_0001, "baud");
		rdc(ADDR_TOUT, 32'h0000_0000, "tout");
		rdc(ADDR_STAT, 32'h0000_0000, "stat");
		apb(1'b0, 12'h018, '0);
		chk("pslverr", 1, er);
		for (int c = 0; c < 5; c++) begin
			wr(ADDR_CTRL, cfgs[c]);
			i_usart_partner.cfg = cfgs[c];
			m = cfgs[c][1:0] == WLEN_7 ? 9'h07F : (cfgs[c][1:0] == WLEN_9 ? 9'h1FF : 9'h0FF);
			fork
				for (int i = 0; i < 3; i++) begin
					v = 9'($urandom) & m;
					exp_tx.push_back(v);
					if (cfgs[c][8]) exp_rx.push_back(v);
					wr(ADDR_DATA, {23'h0, v});
				end
				if (!cfgs[c][8]) for (int j = 0; j < 3; j++) begin
					u = 9'($urandom) & m;
					exp_rx.push_back(u);
					i_usart_partner.send(u, 1'b0, 1'b0);
				end
			join
			wait_got(3);
			apb(1'b0, ADDR_STAT, '0);
			chk("rx level", 3, rd[15:12]);
			chk("tx empty flag", 1, rd[4]);
			while (exp_rx.size() > 0) rdd(exp_rx.pop_front());
			while (exp_tx.size() > 0) chk("tx word", exp_tx.pop_front(), i_usart_partner.got_q.pop_front());
			wr(ADDR_STAT, 32'h0000_007F);
		end
		chk("frame errors", 0, i_usart_partner.bad);
		wr(ADDR_CTRL, 32'h0000_3005);
		i_usart_partner.cfg = 32'h0000_3005;
		wr(ADDR_MASK, 32'h0000_007F);
		i_usart_partner.send(9'h0A5, 1'b1, 1'b0);
		repeat (40) @(posedge clk);
		rdc(ADDR_STAT, 32'h0000_1021, "parity status");
		chk("irq", 1, irq);
		wr(ADDR_STAT, 32'h0000_007F);
		i_usart_partner.send(9'h000, 1'b0, 1'b1);
		repeat (40) @(posedge clk);
		rdc(ADDR_STAT, 32'h0000_200A, "break status");
		wr(ADDR_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk("irq masked", 0, irq);
		apb(1'b0, ADDR_DATA, '0);
		rdd(9'h000);
		for (int f = 0; f < 2; f++) begin
			wr(ADDR_CTRL, f ? 32'h0000_3801 : 32'h0000_3001);
			i_usart_partner.cfg = f ? 32'h0000_3801 : 32'h0000_3001;
			wr(ADDR_STAT, 32'h0000_007F);
			for (int k = 0; k < 9 - f; k++) begin
				u = 9'($urandom) & m;
				if (k < 8) exp_rx.push_back(u);
				i_usart_partner.send(u, 1'b0, 1'b0);
			end
			repeat (40) @(posedge clk);
			chk("rts full", f, rts_n);
			apb(1'b0, ADDR_STAT, '0);
			chk("rx level full", 8, rd[15:12]);
			chk("overrun", !f, rd[2]);
			while (exp_rx.size() > 0) rdd(exp_rx.pop_front());
			repeat (2) @(posedge clk);
			chk("rts drained", 0, rts_n);
		end
		i_usart_partner.stall <= 1'b1;
		wr(ADDR_DATA, 32'h0000_005A);
		repeat (400) @(posedge clk);
		chk("held by cts", 0, i_usart_partner.got_q.size());
		i_usart_partner.stall <= 1'b0;
		wait_got(1);
		chk("sent after cts", 9'h05A, i_usart_partner.got_q.pop_front());
		wr(ADDR_TOUT, 32'h0000_0002);
		i_usart_partner.send(9'h033, 1'b0, 1'b0);
		repeat (150) @(posedge clk);
		apb(1'b0, ADDR_STAT, '0);
		chk("timeout flag", 1, rd[6]);
		rdd(9'h033);
		stop_test();
	end
endmodule
